// ==== design/sfl_dev.sv ====
// Device end: over-current latches, battery handling, serial command slave
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - eight slow, two fast thresholds, both watched
// - slow over blanking time latches output off
// - fast threshold latches and cuts output immediately
// - latch held until command off then on
// - low battery forces off, fault low above dead level, flag
// - recovery with command on stays latched off
// - protection off: follow command above dead level
// - direct input and serial bit are equivalent
// - capture on falling, shift out on rising
// - host keeps clock low across select edges
// - host keeps clock low while deselected
// - deselected: ignore clock/data, output released
// - both words shift MSB first, FIFO path
// - host sends eight bits, MSB first
// - three-bit register address in command word
// - bit7 watchdog/address, 6:4 register, 3:0 value
// - commit on select rise, status on fall
// - frames not multiple of eight ignored
`include "sfl_cfg.svh"
module sfl_dev
  import sfl_pkg::*;
#(
  parameter int unsigned CUR_W   = `SFL_CUR_W,
  parameter int unsigned FAST_LO = `SFL_FAST_LO_A,
  parameter int unsigned FAST_HI = `SFL_FAST_HI_A
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_b,
  sfl_spi_if.dev                spi,
  input  wire logic             i_switch_in,
  input  wire logic [CUR_W-1:0] i_load_amps,
  input  wire logic             i_batt_low,
  input  wire logic             i_batt_dead,
  output logic                  o_out_on,
  output logic                  o_fault_status_n,
  output logic                  o_undervoltage_flag,
  output logic                  o_oc_latched
);

  localparam int unsigned SW = CUR_W + 6;

  logic [SW-1:0]    meta_q;       // First synchroniser stage
  logic [SW-1:0]    sync_q;       // Second synchroniser stage
  logic             cs_n_s;       // Synced select
  logic             sclk_s;       // Synced serial clock
  logic             si_s;         // Synced serial data
  logic             sw_s;         // Synced direct switch input
  logic             low_s;        // Battery below low threshold
  logic             dead_s;       // Battery below dead level
  logic [CUR_W-1:0] amps_s;       // Synced load current
  logic             sclk_p_q;     // Serial clock, one cycle back
  logic             cs_n_p_q;     // Select, one cycle back
  logic             sclk_fall;    // Falling serial clock in frame
  logic             sclk_rise;    // Rising serial clock in frame
  logic             cs_fall;      // Frame start
  logic             cs_rise;      // Frame end
  sfl_byte_t        sr_q;         // Shared in/out shift path
  logic [2:0]       bits_q;       // Bits modulo eight
  logic             any_q;        // At least one bit seen
  logic             commit;       // Whole-byte frame ended
  logic             in_spi_q;     // Serial switch command
  logic [2:0]       socl_q;       // Slow threshold code
  logic             soch_q;       // Fast threshold select
  logic [1:0]       oclt_q;       // Blanking time code
  logic             uv_off_q;     // Under-voltage protection off
  logic             cmd;          // Combined switch command
  logic [CUR_W-1:0] slow_thr;     // Selected slow level
  logic [CUR_W-1:0] fast_thr;     // Selected fast level
  logic             slow_hit;     // Current at or above slow
  logic             fast_hit;     // Current at or above fast
  logic [15:0]      blank_cyc;    // Selected blanking count
  logic [15:0]      blank_q;      // Blanking counter
  logic             ocs_q;        // Slow over-current latch
  logic             ocf_q;        // Fast over-current latch
  logic             uv_lat_q;     // Under-voltage latch
  logic             uv_en;        // Under-voltage protection active
  sfl_status_t      status;       // Word loaded at frame start

  // Register address match on word bits 6:4
  function automatic logic hit(input sfl_byte_t w, input logic [2:0] a);
    return w[6:4] == a;
  endfunction

  // Two-flop synchroniser for every pin input
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_q <= SW'(1);
      sync_q <= SW'(1);
    end else begin
      meta_q <= {i_load_amps, i_batt_dead, i_batt_low, i_switch_in,
                 spi.si, spi.sclk, spi.cs_n};
      sync_q <= meta_q;
    end
  end

  assign cs_n_s = sync_q[0];
  assign sclk_s = sync_q[1];
  assign si_s   = sync_q[2];
  assign sw_s   = sync_q[3];
  assign low_s  = sync_q[4];
  assign dead_s = sync_q[5];
  assign amps_s = sync_q[SW-1:6];

  // Edge history of serial clock and select
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sclk_p_q <= 1'b0;
      cs_n_p_q <= 1'b1;
    end else begin
      sclk_p_q <= sclk_s;
      cs_n_p_q <= cs_n_s;
    end
  end

  // Clock edges only count while selected
  assign sclk_fall = !cs_n_s && sclk_p_q && !sclk_s;
  assign sclk_rise = !cs_n_s && !sclk_p_q && sclk_s;
  assign cs_fall   = cs_n_p_q && !cs_n_s;
  assign cs_rise   = !cs_n_p_q && cs_n_s;
  assign commit    = cs_rise && any_q && (bits_q == 3'h0);

  // Status snapshot
  assign status = '{oc_slow: ocs_q, oc_fast: ocf_q, undervoltage_flag: o_undervoltage_flag,
                    fault: !o_fault_status_n, out_on: o_out_on,
                    in_spi: in_spi_q, uv_off: uv_off_q, sw_in: sw_s};

  // Shift path: status in at select fall, data in on falling clock
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sr_q   <= 8'h00;
      bits_q <= 3'h0;
      any_q  <= 1'b0;
    end else if (cs_fall) begin
      sr_q   <= status;
      bits_q <= 3'h0;
      any_q  <= 1'b0;
    end else if (sclk_fall) begin
      sr_q   <= {sr_q[6:0], si_s};
      bits_q <= bits_q + 3'h1;
      any_q  <= 1'b1;
    end
  end

  // Output bit: MSB first, moves on rising clock, released when idle
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      spi.so      <= 1'b0;
      spi.so_oe_n <= 1'b1;
    end else if (cs_fall) begin
      spi.so      <= status[7];
      spi.so_oe_n <= 1'b0;
    end else if (cs_n_s) begin
      spi.so_oe_n <= 1'b1;
    end else if (sclk_rise) begin
      spi.so      <= sr_q[7];
    end
  end

  // Register bank, written only at the end of a whole-byte frame
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      in_spi_q <= 1'b0;
      socl_q   <= 3'h0;
      soch_q   <= 1'b0;
      oclt_q   <= 2'h0;
      uv_off_q <= 1'b0;
    end else if (commit) begin
      // Address in bits 6:4, value in 3:0
      if (hit(sr_q, `SFL_A_OCR)) begin
        in_spi_q <= sr_q[0];
      end
      if (hit(sr_q, `SFL_A_SOCHLR)) begin
        soch_q <= sr_q[3];
        socl_q <= sr_q[2:0];
      end
      if (hit(sr_q, `SFL_A_CDTOLR)) begin
        oclt_q <= sr_q[1:0];
      end
      // Bit 7 completes the address here
      if (hit(sr_q, `SFL_A_UOVR) && sr_q[7]) begin
        uv_off_q <= sr_q[1];
      end
    end
  end

  // Either command source switches on
  assign cmd   = sw_s | in_spi_q;
  assign uv_en = !uv_off_q;

  // Threshold and blanking selection
  assign slow_thr = CUR_W'(`SFL_SLOW_TOP_A - `SFL_SLOW_STEP_A * socl_q);
  assign fast_thr = soch_q ? CUR_W'(FAST_HI) : CUR_W'(FAST_LO);
  assign slow_hit = o_out_on && (amps_s >= slow_thr);
  assign fast_hit = o_out_on && (amps_s >= fast_thr);

  always_comb begin
    case (oclt_q)
      2'h0:    blank_cyc = 16'(`SFL_BLANK0_CYC);
      2'h1:    blank_cyc = 16'(`SFL_BLANK1_CYC);
      2'h2:    blank_cyc = 16'(`SFL_BLANK2_CYC);
      default: blank_cyc = 16'(`SFL_BLANK3_CYC);
    endcase
  end

  // Over-current latches, cleared only while command is off
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ocs_q   <= 1'b0;
      ocf_q   <= 1'b0;
      blank_q <= 16'h0000;
    end else if (!cmd) begin
      ocs_q   <= 1'b0;
      ocf_q   <= 1'b0;
      blank_q <= 16'h0000;
    end else begin
      if (fast_hit) begin
        ocf_q <= 1'b1;
      end
      if (!slow_hit) begin
        blank_q <= 16'h0000;
      end else if (blank_q >= blank_cyc) begin
        ocs_q <= 1'b1;
      end else begin
        blank_q <= blank_q + 16'h0001;
      end
    end
  end

  // Under-voltage latch: only a drop while commanded on latches
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      uv_lat_q <= 1'b0;
    end else if (!uv_en || !cmd) begin
      uv_lat_q <= 1'b0;
    end else if (low_s) begin
      uv_lat_q <= 1'b1;
    end
  end

  // Under-voltage flag: new drop wins over read clear
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_undervoltage_flag <= 1'b0;
    end else if (uv_en && low_s) begin
      o_undervoltage_flag <= 1'b1;
    end else if (commit || !uv_en) begin
      o_undervoltage_flag <= 1'b0;
    end
  end

  // Switch output and fault pin
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_out_on         <= 1'b0;
      o_fault_status_n <= 1'b1;
      o_oc_latched     <= 1'b0;
    end else begin
      o_out_on <= cmd && !ocs_q && !ocf_q && !fast_hit && !dead_s
                  && !(uv_en && (low_s || uv_lat_q));
      o_fault_status_n <= !(ocs_q || ocf_q)
                          && !(uv_en && !dead_s && (low_s || uv_lat_q));
      o_oc_latched <= ocs_q || ocf_q;
    end
  end

endmodule
`default_nettype wire

// ==== shared/sfl_cfg.svh ====
// Timing, threshold and register-map constants for the switch fault front end
`ifndef SFL_CFG_SVH
`define SFL_CFG_SVH

// System clock rate in MHz
`define SFL_CLK_MHZ 25
// Load-current measurement width in bits
`define SFL_CUR_W 8
// Slow threshold table: top level and step per code, amperes
`define SFL_SLOW_TOP_A 50
`define SFL_SLOW_STEP_A 5
// Fast threshold levels, amperes
`define SFL_FAST_LO_A 100
`define SFL_FAST_HI_A 150
// Over-current blanking times in microseconds and derived cycle counts
`define SFL_BLANK0_US 1
`define SFL_BLANK1_US 2
`define SFL_BLANK2_US 4
`define SFL_BLANK3_US 8
`define SFL_BLANK0_CYC (`SFL_BLANK0_US * `SFL_CLK_MHZ)
`define SFL_BLANK1_CYC (`SFL_BLANK1_US * `SFL_CLK_MHZ)
`define SFL_BLANK2_CYC (`SFL_BLANK2_US * `SFL_CLK_MHZ)
`define SFL_BLANK3_CYC (`SFL_BLANK3_US * `SFL_CLK_MHZ)
// Command word register addresses (word bits 6:4)
`define SFL_A_OCR 3'h1
`define SFL_A_SOCHLR 3'h2
`define SFL_A_CDTOLR 3'h3
`define SFL_A_UOVR 3'h6
// Host serial clock half period in system cycles
`define SFL_HALF_CYC 8
// Host register byte offsets
`define SFL_R_TX 5'h00
`define SFL_R_RX 5'h04
`define SFL_R_BUSY 5'h08
`define SFL_R_ISTAT 5'h0c
`define SFL_R_IMASK 5'h10

`endif

// ==== shared/sfl_pkg.sv ====
// Shared types for the switch fault front end
`default_nettype none
package sfl_pkg;
  // One serial command or status word
  typedef logic [7:0] sfl_byte_t;
  // Status word returned at the start of each frame, MSB first
  typedef struct packed {
    logic oc_slow;
    logic oc_fast;
    logic undervoltage_flag;
    logic fault;
    logic out_on;
    logic in_spi;
    logic uv_off;
    logic sw_in;
  } sfl_status_t;
  // Host frame sequencer states
  typedef enum logic [1:0] {
    SFL_IDLE  = 2'b00,
    SFL_LEAD  = 2'b01,
    SFL_SHIFT = 2'b10,
    SFL_TAIL  = 2'b11
  } sfl_host_st_t;
endpackage
`default_nettype wire

// ==== shared/sfl_spi_if.sv ====
// Serial link between host controller and switch device
`timescale 1ns/1ns
`default_nettype none
interface sfl_spi_if;
  logic sclk;     // Serial clock from host
  logic si;       // Command data toward device
  logic cs_n;     // Frame select, active low
  logic so;       // Device output data
  logic so_oe_n;  // Low while device drives output
  logic so_line;  // Resolved output wire, pulled low when idle
  assign so_line = so_oe_n ? 1'b0 : so;
  modport dev (input sclk, input si, input cs_n, output so, output so_oe_n);
  modport host (output sclk, output si, output cs_n, input so_line);
endinterface
`default_nettype wire

// ==== design/sfl_host.sv ====
// Host end: Wishbone-controlled serial master with done interrupt
`timescale 1ns/1ns
`default_nettype none
`include "sfl_cfg.svh"
module sfl_host
  import sfl_pkg::*;
#(
  parameter int unsigned HALF = `SFL_HALF_CYC
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  sfl_spi_if.host          spi,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [4:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic             o_wb_ack,
  output logic [31:0]      o_wb_dat,
  output logic             o_irq
);

  sfl_host_st_t st_q;      // Frame sequencer state
  logic [7:0]   div_q;     // Half-period divider
  logic         tick;      // One-cycle half-period enable
  sfl_byte_t    tx_q;      // Last byte that started a frame
  sfl_byte_t    txsr_q;    // Outgoing shift register
  sfl_byte_t    rx_q;      // Incoming shift register
  logic [2:0]   nbit_q;    // Bits remaining minus one
  logic         done_q;    // Frame-complete pulse
  logic         istat_q;   // Sticky done status
  logic         imask_q;   // Done interrupt enable
  logic         acc;       // Bus access this cycle
  logic         wr0;       // Write with low byte lane
  logic         start;     // Start request accepted

  assign acc   = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wr0   = acc && i_wb_we && i_wb_sel[0];
  assign start = wr0 && (i_wb_adr == `SFL_R_TX) && (st_q == SFL_IDLE);
  assign tick  = (div_q == 8'(HALF - 1));

  // Divider runs only during a frame
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_q <= 8'h00;
    end else if (st_q == SFL_IDLE || tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // Frame sequencer; clock low at every select edge
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q     <= SFL_IDLE;
      spi.cs_n <= 1'b1;
      spi.sclk <= 1'b0;
      spi.si   <= 1'b0;
      txsr_q   <= 8'h00;
      rx_q     <= 8'h00;
      nbit_q   <= 3'h0;
      done_q   <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        SFL_IDLE: begin
          if (start) begin
            spi.cs_n <= 1'b0;
            spi.si   <= i_wb_dat[7];
            txsr_q   <= i_wb_dat[7:0];
            nbit_q   <= 3'h7;
            st_q     <= SFL_LEAD;
          end
        end
        SFL_LEAD: begin
          if (tick) begin
            st_q <= SFL_SHIFT;
          end
        end
        SFL_SHIFT: begin
          if (tick && !spi.sclk) begin
            // Rising: next data bit, MSB first
            spi.sclk <= 1'b1;
            spi.si   <= txsr_q[7];
            txsr_q   <= {txsr_q[6:0], 1'b0};
          end else if (tick) begin
            // Falling: sample device output
            spi.sclk <= 1'b0;
            rx_q     <= {rx_q[6:0], spi.so_line};
            nbit_q   <= nbit_q - 3'h1;
            if (nbit_q == 3'h0) begin
              st_q <= SFL_TAIL;
            end
          end
        end
        SFL_TAIL: begin
          if (tick) begin
            spi.cs_n <= 1'b1;
            done_q   <= 1'b1;
            st_q     <= SFL_IDLE;
          end
        end
        default: st_q <= SFL_IDLE;
      endcase
    end
  end

  // Interrupt status, mask and level output; new event beats clear
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      istat_q <= 1'b0;
      imask_q <= 1'b0;
      o_irq   <= 1'b0;
    end else begin
      if (done_q) begin
        istat_q <= 1'b1;
      end else if (wr0 && i_wb_adr == `SFL_R_ISTAT && i_wb_dat[0]) begin
        istat_q <= 1'b0;
      end
      if (wr0 && i_wb_adr == `SFL_R_IMASK) begin
        imask_q <= i_wb_dat[0];
      end
      o_irq <= istat_q && imask_q;
    end
  end

  // Bus answer one cycle after request, read data with it
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
      tx_q     <= 8'h00;
    end else begin
      o_wb_ack <= acc;
      if (start) begin
        tx_q <= i_wb_dat[7:0];
      end
      if (acc) begin
        case (i_wb_adr)
          `SFL_R_TX:    o_wb_dat <= {24'h000000, tx_q};
          `SFL_R_RX:    o_wb_dat <= {24'h000000, rx_q};
          `SFL_R_BUSY:  o_wb_dat <= {31'h0, st_q != SFL_IDLE};
          `SFL_R_ISTAT: o_wb_dat <= {31'h0, istat_q};
          `SFL_R_IMASK: o_wb_dat <= {31'h0, imask_q};
          default:      o_wb_dat <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ==== verification/sfl_link_sva.sv ====
// Wire-level checks on the serial link between host and device
`timescale 1ns/1ns
`default_nettype none
module sfl_link_sva #(
  parameter int HALF = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic sclk,
  input wire logic si,
  input wire logic cs_n,
  input wire logic so,
  input wire logic so_oe_n,
  input wire logic so_line
);
  logic [3:0] edges_q; // Clock rises seen in this frame

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  // Count clock rises while selected
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      edges_q <= 4'h0;
    end else begin
      edges_q <= cs_n ? 4'h0 : edges_q + {3'h0, $rose(sclk)};
    end
  end

  a_cs_edge_sclk: assert property (($fell(cs_n) || $rose(cs_n)) |-> !(sclk || $past(sclk)))
    else $error("serial clock high at a select edge");
  a_idle_sclk: assert property (cs_n |-> !sclk)
    else $error("serial clock high while deselected");
  a_idle_so_off: assert property (cs_n [*6] |-> so_oe_n)
    else $error("device drives output while deselected");
  a_so_on_select: assert property ($fell(cs_n) |-> ##[2:6] !so_oe_n)
    else $error("device output not enabled after select");
  a_si_at_rise: assert property ((!cs_n && !$past(cs_n) && $changed(si)) |-> $rose(sclk))
    else $error("command data moved off the clock rise");
  a_sclk_high: assert property ($rose(sclk) |-> ##HALF $fell(sclk))
    else $error("serial clock high phase wrong length");
  a_lead_time: assert property ($fell(cs_n) |-> ##(2*HALF) $rose(sclk))
    else $error("first clock rise not two half periods after select");
  a_bit_count: assert property ($rose(cs_n) |-> edges_q == 4'h8)
    else $error("frame not eight clock pulses");

  // Main scenarios reached
  c_frame: cover property ($rose(cs_n));
  c_so_on: cover property ($fell(so_oe_n));
  c_so_one: cover property (!so_oe_n && so && so_line);
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// Bench joining host and device, with a model and a rule-breaking link driver
`timescale 1ns/1ns
`default_nettype none
`include "sfl_cfg.svh"
module tb_top;
  import sfl_pkg::*;
  logic        i_sys_clk = 1'b0; // System clock
  logic        i_rst_b = 1'b0;   // Reset, active low
  logic        cyc = 1'b0;       // Bus cycle
  logic        stb = 1'b0;       // Bus strobe
  logic        we = 1'b0;        // Bus direction
  logic [4:0]  adr = 5'h00;      // Bus address
  logic [31:0] wdat = 32'h0;     // Bus write data
  logic        sw = 1'b0;        // Direct switch command
  logic        blow = 1'b0;      // Battery low
  logic        bdead = 1'b0;     // Battery below dead level
  logic [7:0]  amps = 8'h00;     // Load current
  logic        ack, irq, out_on, flt_n, undervoltage_flag, ocl, out_b;
  logic [31:0] rdat;
  logic [15:0] r;
  int          err_total = 0;
  int          checks = 0;
  int          m_spi, m_code, m_fsel, m_blank, m_uvoff, m_ls, m_lf, m_uvf, m_uvl; // Model

  sfl_spi_if spi_a ();
  sfl_spi_if spi_b ();
  sfl_host sfl_host_i (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .spi(spi_a.host),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf),
    .i_wb_dat(wdat), .o_wb_ack(ack), .o_wb_dat(rdat), .o_irq(irq));
  sfl_dev sfl_dev_i (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .spi(spi_a.dev),
    .i_switch_in(sw), .i_load_amps(amps), .i_batt_low(blow), .i_batt_dead(bdead),
    .o_out_on(out_on), .o_fault_status_n(flt_n), .o_undervoltage_flag(undervoltage_flag), .o_oc_latched(ocl));
  sfl_dev sfl_dev_b_i (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .spi(spi_b.dev),
    .i_switch_in(sw), .i_load_amps(amps), .i_batt_low(blow), .i_batt_dead(bdead),
    .o_out_on(out_b), .o_fault_status_n(), .o_undervoltage_flag(), .o_oc_latched());
  sfl_link_sva #(.HALF(`SFL_HALF_CYC)) sfl_link_sva_i (.i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b), .sclk(spi_a.sclk), .si(spi_a.si), .cs_n(spi_a.cs_n),
    .so(spi_a.so), .so_oe_n(spi_a.so_oe_n), .so_line(spi_a.so_line));

  // 25 MHz clock
  always #20 i_sys_clk = ~i_sys_clk;

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic test_done();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One classic bus cycle, held until ack
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (n >= 40) chk(32'h0, 32'h1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge i_sys_clk);
  endtask

  // Model: status byte, MSB first
  function automatic logic [7:0] mst();
    logic cmd, uvb, eo, ef;
    cmd = sw | m_spi[0];
    uvb = !m_uvoff[0] && (blow || m_uvl[0]);
    eo = cmd && !m_ls[0] && !m_lf[0] && !uvb && !bdead;
    ef = !(m_ls[0] || m_lf[0] || uvb);
    return {m_ls[0], m_lf[0], m_uvf[0], !ef, eo, m_spi[0], m_uvoff[0], sw};
  endfunction

  // Settle, then compare device pins with the model
  task automatic pins();
    logic [7:0] s;
    repeat (8) @(posedge i_sys_clk);
    s = mst();
    chk({out_on, flt_n, undervoltage_flag, ocl}, {s[3], !s[4], s[5], s[7] | s[6]});
  endtask

  // Send a byte through the host, check the returned status, update model
  task automatic frame(input logic [7:0] b);
    logic [31:0] q;
    logic [7:0]  e;
    int          n;
    e = mst();
    n = 0;
    wb(1'b1, `SFL_R_TX, {24'h0, b}, q);
    do begin
      wb(1'b0, `SFL_R_BUSY, 32'h0, q);
      n++;
    end while (q[0] !== 1'b0 && n < 200);
    wb(1'b0, `SFL_R_RX, 32'h0, q);
    chk(q, {24'h0, e});
    case (b[6:4])
      `SFL_A_OCR: m_spi = b[0];
      `SFL_A_SOCHLR: m_code = b[2:0];
      `SFL_A_CDTOLR: m_blank = b[1:0];
      `SFL_A_UOVR: if (b[7]) m_uvoff = b[1];
      default: ;
    endcase
    m_uvf = blow && !m_uvoff[0];
    if (!(sw | m_spi[0])) begin
      m_ls = 0;
      m_lf = 0;
      m_uvl = 0;
    end
  endtask

  // Bit-banged frame on the second link, any length
  task automatic bb(input logic [15:0] d, input int nb, output logic [15:0] q);
    q = 16'h0;
    spi_b.cs_n <= 1'b0;
    for (int i = nb - 1; i >= 0; i--) begin
      repeat (8) @(posedge i_sys_clk);
      spi_b.sclk <= 1'b1;
      spi_b.si <= d[i];
      repeat (8) @(posedge i_sys_clk);
      spi_b.sclk <= 1'b0;
      q[i] = spi_b.so_line;
    end
    repeat (8) @(posedge i_sys_clk);
    spi_b.cs_n <= 1'b1;
    repeat (8) @(posedge i_sys_clk);
  endtask

  // Watchdog on a hung run
  initial begin
    #2000000;
    err_total++;
    test_done();
  end

  // Main sequence
  initial begin
    logic [31:0] q;
    int lv;
    spi_b.sclk = 1'b0;
    spi_b.si = 1'b0;
    spi_b.cs_n = 1'b1;
    void'($urandom(32'hc096));
    repeat (4) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    @(posedge i_sys_clk);
    pins();
    wb(1'b0, `SFL_R_IMASK, 32'h0, q);
    chk(q, 32'h0);
    wb(1'b0, 5'h14, 32'h0, q);
    chk(q, 32'h0);
    wb(1'b1, `SFL_R_IMASK, 32'h1, q);
    frame(8'h11);
    pins();
    wb(1'b0, `SFL_R_TX, 32'h0, q);
    chk(q, 32'h11);
    chk(irq, 1'b1);
    wb(1'b1, `SFL_R_ISTAT, 32'h1, q);
    wb(1'b0, `SFL_R_ISTAT, 32'h0, q);
    chk({q[0], irq}, 2'b00);
    wb(1'b1, `SFL_R_IMASK, 32'h0, q);
    frame(8'h11);
    wb(1'b0, `SFL_R_ISTAT, 32'h0, q);
    chk({q[0], irq}, 2'b10);
    wb(1'b1, `SFL_R_ISTAT, 32'h1, q);
    wb(1'b1, `SFL_R_IMASK, 32'h1, q);
    // Every slow level, every blanking code
    for (int c = 0; c < 8; c++) begin
      frame({1'b0, 3'h2, 1'b0, c[2:0]});
      frame({1'b0, 3'h3, 2'b00, c[1:0]});
      lv = 50 - 5 * c;
      amps <= 8'($urandom_range(lv - 1));
      repeat (250) @(posedge i_sys_clk);
      pins();
      amps <= lv[7:0];
      repeat ((25 << c[1:0]) - 4) @(posedge i_sys_clk);
      chk(out_on, 1'b1);
      repeat (12) @(posedge i_sys_clk);
      m_ls = 1;
      pins();
      amps <= 8'h00;
      frame(8'h10);
      pins();
      frame(8'h11);
      pins();
    end
    // Both fast levels, no blanking
    frame(8'h33);
    for (int f = 0; f < 2; f++) begin
      frame({1'b0, 3'h2, f[0], 3'h0});
      lv = f ? 150 : 100;
      amps <= 8'(lv - 1);
      repeat (12) @(posedge i_sys_clk);
      chk(out_on, 1'b1);
      amps <= lv[7:0];
      repeat (6) @(posedge i_sys_clk);
      chk(out_on, 1'b0);
      m_lf = 1;
      pins();
      amps <= 8'h00;
      frame(8'h10);
      frame(8'h11);
      pins();
    end
    frame(8'h10);
    // Battery drop with command off, then on through the direct input
    for (int k = 0; k < 2; k++) begin
      sw <= k[0];
      pins();
      blow <= 1'b1;
      m_uvf = 1;
      m_uvl = k;
      pins();
      blow <= 1'b0;
      pins();
      sw <= 1'b0;
      m_uvl = 0;
      pins();
      frame(8'h00);
      pins();
    end
    // Protection off needs the address bit set
    frame(8'h62);
    frame(8'he2);
    frame(8'h11);
    blow <= 1'b1;
    pins();
    bdead <= 1'b1;
    pins();
    blow <= 1'b0;
    bdead <= 1'b0;
    pins();
    frame(8'h10);
    // Second link: clock and data moving while deselected
    for (int i = 0; i < 8; i++) begin
      spi_b.sclk <= i[0];
      spi_b.si <= ~i[0];
      repeat (4) @(posedge i_sys_clk);
      chk(spi_b.so_oe_n, 1'b1);
    end
    spi_b.sclk <= 1'b0;
    @(posedge i_sys_clk);
    bb(16'h0011, 7, r);
    chk(out_b, 1'b0);
    bb(16'h1110, 16, r);
    chk({out_b, r}, {1'b0, 16'h2011});
    bb(16'h1011, 16, r);
    chk({out_b, r}, {1'b1, 16'h0010});
    test_done();
  end
endmodule
`default_nettype wire
